/* rtl/vmr_pkg.sv */
/*
 * Shared constants and types for the VMEbus master requester.
 * Assumes an APB master on pclk and active-low open-drain VMEbus lines.
 */
package vmr_pkg;
	// Register byte offsets
	localparam logic [7:0] VMR_CTRL_OFF   = 8'h00;
	localparam logic [7:0] VMR_STATUS_OFF = 8'h04;
	localparam logic [7:0] VMR_LIMIT_OFF  = 8'h08;
	// Control field positions
	localparam int VMR_HOLD_BIT    = 0;
	localparam int VMR_RMODE_BIT   = 1;
	localparam int VMR_RELMODE_BIT = 2;
	localparam int VMR_HIRQEN_BIT  = 3;
	localparam int VMR_LEVEL_LSB   = 4;
	localparam int VMR_POSTED_TENURE_BYTES_LSB    = 8;
	// Reset values, plus the byte field code that ends PCI tenure after each posted write
	localparam logic [1:0] VMR_LEVEL_RST  = 2'h3;
	localparam logic [3:0] VMR_POSTED_TENURE_BYTES_RST   = 4'h0;
	localparam logic [3:0] VMR_POSTED_TENURE_BYTES_EACH  = 4'hf;
	localparam logic [7:0] VMR_OFF_RST    = 8'h10;
	localparam logic [7:0] VMR_DMABYT_RST = 8'h40;
	// Timing: DMA off time figure in ns per off-timer unit
	localparam int VMR_CLK_NS      = 25;
	localparam int VMR_OFF_UNIT_NS = 100;
	localparam int VMR_OFF_UNIT_CYC = (VMR_OFF_UNIT_NS + VMR_CLK_NS - 1) / VMR_CLK_NS;

	typedef enum logic [1:0] {
		VMR_CH_NONE,
		VMR_CH_IRQ,
		VMR_CH_PCI,
		VMR_CH_DMA
	} vmr_chan_t;

	typedef enum logic [1:0] {
		VMR_IDLE,
		VMR_REQ,
		VMR_OWN
	} vmr_state_t;

	typedef struct packed {
		logic       irq_pend;
		logic       posted_write_fifo_full_txn;
		logic       coupled_req;
		logic       dma_ready;
		logic       dma_block_done;
	} vmr_req_t;

	typedef struct packed {
		logic       iack_done;
		logic       fifo_empty;
		logic [7:0] bytes;
		logic       write_done;
		logic       coupled_done;
		logic       coupled_win_exp;
		logic       coupled_req_exp;
		logic       dma_full;
		logic       dma_empty;
		logic       dma_err;
		logic       dma_bytes_exp;
	} vmr_done_t;
endpackage

/* rtl/vmr_requester.sv */
/*
 * VMEbus master requester: internal arbitration among interrupt, PCI target
 * and DMA channels, bus request/release, bus hold, and APB control registers.
 * Assumes VMEbus lines are active-low open-drain, driven via output enables.
 */
// Overview of operation
// - Interrupt channel always wins the master interface when requesting.
// - DMA and PCI target channels share the interface fairly.
// - Winner keeps ownership until its own completion condition holds.
// - Interrupt channel requests on enabled interrupt needing an acknowledge cycle.
// - PCI target requests on complete posted transaction or coupled request.
// - DMA requests on 64 bytes space/data or block completion.
// - DMA off-timer holds DMA off the bus for programmed interval.
// - Bus hold bit acquires the bus, then sets acknowledge, optional interrupt, except if set while the bus is owned in release-on-request mode.
// - During a hold tenure only PCI target and interrupt channels run.
// - Request on one of four levels, default 3, for all channels.
// - Fair mode waits until no request pending on own level.
// - Demand mode, default, requests regardless of level line.
// - Release-when-done, default, frees bus whenever owner is done outside a hold tenure.
// - Own-busy status reads 0 while driving bus busy.
// - Interrupt tenure ends after one acknowledge cycle.
// - PCI tenure ends on empty posted FIFO or byte limit.
// - Byte field 0b1111 ends PCI tenure after each posted write.
// - Coupled tenure ends on completion plus window, or request timeout.
// - DMA tenure ends on full, empty, error, byte count, or block done.
`timescale 1ns/10ps
module vmr_requester #(
	parameter int LIMIT_W = 8
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Channel requests and completion events
	input  wire vmr_pkg::vmr_req_t  chan_req,
	input  wire vmr_pkg::vmr_done_t chan_done,
	input  wire logic              dma_to_pci,
	// VMEbus, active low: br_n[3:0], bbsy_n, bg_in_n
	input  wire logic [3:0]        br_n_in,
	input  wire logic              bbsy_n_in,
	input  wire logic              bg_in_n,
	input  wire logic              bclr_n,
	output logic      [3:0]        br_n_out,
	output logic      [3:0]        br_n_oe,
	output logic                   bbsy_n_out,
	output logic                   bbsy_n_oe,
	// Grant to master interface and hold interrupt
	output vmr_pkg::vmr_chan_t     grant,
	output logic                   hold_irq
);
	typedef struct packed {
		vmr_pkg::vmr_state_t fsm;
		vmr_pkg::vmr_chan_t  owner;
		vmr_pkg::vmr_chan_t  last;
		logic                bus_hold_request;
		logic                bus_hold_ack;
		logic                hold_tenure;
		logic                request_mode_bit;
		logic                release_mode_bit;
		logic                hold_irq_en;
		logic [1:0]          request_level_field;
		logic [3:0]          posted_tenure_bytes;
		logic [LIMIT_W-1:0]  off_time;
		logic [LIMIT_W-1:0]  dma_limit;
		logic [LIMIT_W-1:0]  off_cnt;
		logic [1:0]          off_pre;
		logic [LIMIT_W+3:0]  pci_bytes;
		logic [LIMIT_W-1:0]  dma_bytes;
		logic [31:0]         prdata;
		logic                pready;
		logic                pslverr;
		logic [3:0]          br_oe;
		logic                bbsy_oe;
		logic                hold_irq;
		logic [3:0][3:0]     br_hist;
	} vmr_st_t;

	vmr_st_t    st_q;
	vmr_st_t    st_d;
	logic [5:0] sy;
	logic [3:0] br_s;
	logic       bbsy_s;
	logic       bg_s;

	// Bus clear deliberately unused
	vmr_sync #(.W(6)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.din     ({br_n_in, bbsy_n_in, bg_in_n}),
		.dout    (sy)
	);
	assign br_s   = ~sy[5:2];
	assign bbsy_s = ~sy[1];
	assign bg_s   = ~sy[0];

	function automatic logic chan_finished(input vmr_st_t s, input vmr_pkg::vmr_done_t d,
			input logic to_pci, input logic blk);
		logic f;
		f = 1'b0;
		unique case (s.owner)
			vmr_pkg::VMR_CH_IRQ: f = d.iack_done;
			vmr_pkg::VMR_CH_PCI: f = d.fifo_empty
				|| (s.posted_tenure_bytes == vmr_pkg::VMR_POSTED_TENURE_BYTES_EACH && d.write_done)
				|| (s.posted_tenure_bytes != vmr_pkg::VMR_POSTED_TENURE_BYTES_EACH
					&& s.posted_tenure_bytes != 4'h0
					&& s.pci_bytes >= {s.posted_tenure_bytes, {LIMIT_W{1'b0}}})
				|| (d.coupled_done && d.coupled_win_exp) || d.coupled_req_exp;
			vmr_pkg::VMR_CH_DMA: f = (to_pci && d.dma_full) || (!to_pci && d.dma_empty)
				|| d.dma_err || d.dma_bytes_exp || blk;
			default: f = 1'b0;
		endcase
		return f;
	endfunction

	logic irq_w;
	logic pci_w;
	logic dma_w;
	logic any_w;
	logic done_w;
	logic others_req;
	vmr_pkg::vmr_chan_t pick;

	always_comb begin
		irq_w = chan_req.irq_pend;
		pci_w = chan_req.posted_write_fifo_full_txn || chan_req.coupled_req;
		dma_w = (chan_req.dma_ready || chan_req.dma_block_done) && st_q.off_cnt == '0
			&& st_q.off_pre == '0 && !st_q.hold_tenure && !st_q.bus_hold_request;
		any_w = irq_w || pci_w || dma_w || st_q.bus_hold_request;
		// round robin between PCI and DMA
		if (irq_w) begin
			pick = vmr_pkg::VMR_CH_IRQ;
		end else if (pci_w && dma_w) begin
			pick = (st_q.last == vmr_pkg::VMR_CH_PCI) ? vmr_pkg::VMR_CH_DMA
				: vmr_pkg::VMR_CH_PCI;
		end else if (pci_w) begin
			pick = vmr_pkg::VMR_CH_PCI;
		end else if (dma_w) begin
			pick = vmr_pkg::VMR_CH_DMA;
		end else begin
			pick = vmr_pkg::VMR_CH_NONE;
		end
		done_w     = chan_finished(st_q, chan_done, dma_to_pci, chan_req.dma_block_done);
		// Own request lingers in the synchroniser for a few cycles; mask it
		others_req = |(br_s & st_q.br_oe & ~(st_q.br_hist[0] | st_q.br_hist[1]
			| st_q.br_hist[2] | st_q.br_hist[3]));
	end

	always_comb begin
		st_d         = st_q;
		st_d.pready  = 1'b0;
		st_d.pslverr = 1'b0;
		st_d.hold_irq = 1'b0;
		st_d.br_hist  = {st_q.br_hist[2:0], ~st_q.br_oe};
		// APB access phase, single-cycle answer
		if (psel && !penable) begin
			st_d.pready = 1'b1;
			st_d.prdata = '0;
			unique case (paddr)
				vmr_pkg::VMR_CTRL_OFF: st_d.prdata = {20'h00000, st_q.posted_tenure_bytes,
					2'h0, st_q.request_level_field, st_q.hold_irq_en, st_q.release_mode_bit,
					st_q.request_mode_bit, st_q.bus_hold_request};
				vmr_pkg::VMR_STATUS_OFF: st_d.prdata = {26'h0000000, st_q.owner,
					chan_done.fifo_empty, !st_q.bbsy_oe ? 1'b0 : 1'b1, st_q.bus_hold_ack, 1'b0}
					>> 1;
				vmr_pkg::VMR_LIMIT_OFF: st_d.prdata = {16'h0000,
					8'(st_q.dma_limit), 8'(st_q.off_time)};
				default: st_d.pslverr = 1'b1;
			endcase
		end
		if (psel && penable && st_q.pready && pwrite && !st_q.pslverr) begin
			unique case (paddr)
				vmr_pkg::VMR_CTRL_OFF: begin
					st_d.bus_hold_request    = pwdata[vmr_pkg::VMR_HOLD_BIT];
					st_d.request_mode_bit    = pwdata[vmr_pkg::VMR_RMODE_BIT];
					st_d.release_mode_bit    = pwdata[vmr_pkg::VMR_RELMODE_BIT];
					st_d.hold_irq_en         = pwdata[vmr_pkg::VMR_HIRQEN_BIT];
					st_d.request_level_field = pwdata[vmr_pkg::VMR_LEVEL_LSB +: 2];
					st_d.posted_tenure_bytes = pwdata[vmr_pkg::VMR_POSTED_TENURE_BYTES_LSB +: 4];
				end
				vmr_pkg::VMR_LIMIT_OFF: begin
					st_d.off_time  = LIMIT_W'(pwdata[7:0]);
					st_d.dma_limit = LIMIT_W'(pwdata[15:8]);
				end
				default: ;
			endcase
		end
		if (!st_d.bus_hold_request) begin
			st_d.bus_hold_ack = 1'b0;
		end
		if (st_q.off_pre != '0) begin
			st_d.off_pre = st_q.off_pre - 2'h1;
		end else if (st_q.off_cnt != '0) begin
			st_d.off_cnt = st_q.off_cnt - LIMIT_W'(1);
			st_d.off_pre = 2'(vmr_pkg::VMR_OFF_UNIT_CYC - 1);
		end
		unique case (st_q.fsm)
			vmr_pkg::VMR_IDLE: begin
				if (any_w) begin
					st_d.fsm = vmr_pkg::VMR_REQ;
				end
			end
			vmr_pkg::VMR_REQ: begin
				if (!st_q.request_mode_bit || !br_s[st_q.request_level_field]
						|| st_q.br_oe[st_q.request_level_field] == 1'b0) begin
					st_d.br_oe = 4'hf;
					st_d.br_oe[st_q.request_level_field] = 1'b0;
				end
				if (bg_s && !bbsy_s && st_q.br_oe != 4'hf) begin
					st_d.br_oe   = 4'hf;
					st_d.bbsy_oe = 1'b0;
					st_d.fsm     = vmr_pkg::VMR_OWN;
					st_d.owner   = pick;
					st_d.pci_bytes = '0;
					if (st_q.bus_hold_request) begin
						st_d.hold_tenure  = 1'b1;
						st_d.bus_hold_ack = 1'b1;
						st_d.hold_irq     = st_q.hold_irq_en;
					end
				end
			end
			vmr_pkg::VMR_OWN: begin
				if (st_q.owner == vmr_pkg::VMR_CH_PCI) begin
					st_d.pci_bytes = st_q.pci_bytes + (LIMIT_W+4)'(chan_done.bytes);
				end
				if (st_q.owner != vmr_pkg::VMR_CH_NONE && done_w) begin
					st_d.last  = st_q.owner;
					st_d.owner = vmr_pkg::VMR_CH_NONE;
					if (st_q.owner == vmr_pkg::VMR_CH_DMA) begin
						st_d.off_cnt = st_q.off_time;
					end
				end else if (st_q.owner == vmr_pkg::VMR_CH_NONE && pick != vmr_pkg::VMR_CH_NONE
						&& (st_q.hold_tenure || !others_req)) begin
					st_d.owner     = pick;
					st_d.pci_bytes = '0;
				end
				if (st_q.owner == vmr_pkg::VMR_CH_NONE && st_d.owner == vmr_pkg::VMR_CH_NONE
						&& !st_q.bus_hold_request
						&& (!st_q.release_mode_bit || others_req)) begin
					st_d.bbsy_oe     = 1'b1;
					st_d.hold_tenure = 1'b0;
					st_d.fsm         = vmr_pkg::VMR_IDLE;
				end else if (!st_q.release_mode_bit && st_q.owner != vmr_pkg::VMR_CH_NONE
						&& done_w && !st_q.hold_tenure) begin
					st_d.bbsy_oe = 1'b1;
					st_d.fsm     = vmr_pkg::VMR_IDLE;
				end
			end
			default: st_d.fsm = vmr_pkg::VMR_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q                     <= '0;
			st_q.fsm                 <= vmr_pkg::VMR_IDLE;
			st_q.request_level_field <= vmr_pkg::VMR_LEVEL_RST;
			st_q.posted_tenure_bytes <= vmr_pkg::VMR_POSTED_TENURE_BYTES_RST;
			st_q.off_time            <= LIMIT_W'(vmr_pkg::VMR_OFF_RST);
			st_q.dma_limit           <= LIMIT_W'(vmr_pkg::VMR_DMABYT_RST);
			st_q.br_oe               <= 4'hf;
			st_q.bbsy_oe             <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	assign prdata     = st_q.prdata;
	assign pready     = st_q.pready;
	assign pslverr    = st_q.pslverr;
	assign br_n_out   = 4'h0;
	assign br_n_oe    = st_q.br_oe;
	assign bbsy_n_out = 1'b0;
	assign bbsy_n_oe  = st_q.bbsy_oe;
	assign grant      = st_q.owner;
	assign hold_irq   = st_q.hold_irq;

	logic unused_bclr;
	assign unused_bclr = bclr_n;

	irq_first_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_q.fsm == vmr_pkg::VMR_REQ && bg_s && !bbsy_s && st_q.br_oe != 4'hf && irq_w
		|=> st_q.owner == vmr_pkg::VMR_CH_IRQ)
		else $error("interrupt channel not granted first");
	hold_no_dma_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_q.hold_tenure |-> st_q.owner != vmr_pkg::VMR_CH_DMA)
		else $error("DMA owned during hold tenure");
	hold_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_q.hold_tenure && st_q.bus_hold_request |=> !st_q.bbsy_oe)
		else $error("bus busy released while hold set");
	hold_ack_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(st_q.bus_hold_ack) |-> !st_q.bbsy_oe)
		else $error("hold acknowledged without bus");
	level_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_q.br_oe != 4'hf |-> $onehot(~st_q.br_oe))
		else $error("request on more than one level");
	owner_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_q.owner != vmr_pkg::VMR_CH_NONE && !done_w |=> st_q.owner == $past(st_q.owner))
		else $error("owner changed before done");
	dma_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_q.off_cnt != '0 |-> !dma_w)
		else $error("DMA requested during off time");
	rwd_rel_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_q.fsm == vmr_pkg::VMR_OWN && !st_q.release_mode_bit && done_w && !st_q.hold_tenure
		&& st_q.owner != vmr_pkg::VMR_CH_NONE |=> st_q.bbsy_oe)
		else $error("bus busy not released when done");
	c_irq_c: cover property (@(posedge pclk) st_q.owner == vmr_pkg::VMR_CH_IRQ);
	c_dma_c: cover property (@(posedge pclk) st_q.owner == vmr_pkg::VMR_CH_DMA);
	c_hold_c: cover property (@(posedge pclk) $rose(st_q.bus_hold_ack));
endmodule

/* rtl/vmr_sync.sv */
/*
 * Three-stage synchroniser for asynchronous VMEbus levels.
 * Assumes a free-running pclk; output changes only when stages two and three agree.
 */
`timescale 1ns/10ps
module vmr_sync #(
	parameter int W = 6
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] o;
	} vmr_sync_st_t;

	vmr_sync_st_t st_q;
	vmr_sync_st_t st_d;

	always_comb begin
		st_d    = st_q;
		st_d.s1 = din;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		for (int i = 0; i < W; i++) begin
			if (st_q.s2[i] == st_q.s3[i]) begin
				st_d.o[i] = st_q.s3[i];
			end
		end
	end

	// Lines idle high, so reset to released
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '1;
		end else begin
			st_q <= st_d;
		end
	end

	assign dout = st_q.o;
endmodule

/* testbench/tb_top.sv */
/*
 * Self-checking bench for vmr_requester: APB register rows, then bus
 * scenarios. Assumes vmr_bus_model stands on the bus side.
 */
`timescale 1ns/10ps
module tb_top;
	localparam vmr_pkg::vmr_chan_t ch_non = vmr_pkg::VMR_CH_NONE;
	localparam vmr_pkg::vmr_chan_t ch_irq = vmr_pkg::VMR_CH_IRQ;
	localparam vmr_pkg::vmr_chan_t ch_pci = vmr_pkg::VMR_CH_PCI;
	localparam vmr_pkg::vmr_chan_t ch_dma = vmr_pkg::VMR_CH_DMA;
	// Row: write, address, write data, read data, error
	localparam logic [73:0] rows [9] = '{
		{1'b0, 8'h00, 32'h0, 32'h30, 1'b0}, {1'b0, 8'h08, 32'h0, 32'h4010, 1'b0},
		{1'b0, 8'h0c, 32'h0, 32'h0, 1'b1}, {1'b1, 8'h0c, 32'hffffffff, 32'h0, 1'b1},
		{1'b1, 8'h00, 32'h136, 32'h0, 1'b0}, {1'b0, 8'h00, 32'h0, 32'h136, 1'b0},
		{1'b1, 8'h00, 32'h30, 32'h0, 1'b0}, {1'b1, 8'h08, 32'h4014, 32'h0, 1'b0},
		{1'b0, 8'h08, 32'h0, 32'h4014, 1'b0}};
	logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]         paddr;
	logic [31:0]        pwdata, prdata, rd;
	logic               err, dma_to_pci, bclr_n, other_bbsy, hold_irq;
	logic               bbsy_n_out, bbsy_n_oe, bbsy_n_in, bg_in_n;
	logic [3:0]         br_n_out, br_n_oe, br_n_in, other_br, lat;
	vmr_pkg::vmr_req_t  rq;
	vmr_pkg::vmr_done_t cd;
	vmr_pkg::vmr_chan_t grant, nx;
	int                 miscompares = 0, checks_done = 0, cyc = 0, n;

	vmr_requester dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .chan_req(rq), .chan_done(cd), .dma_to_pci(dma_to_pci),
		.br_n_in(br_n_in), .bbsy_n_in(bbsy_n_in), .bg_in_n(bg_in_n), .bclr_n(bclr_n),
		.br_n_out(br_n_out), .br_n_oe(br_n_oe), .bbsy_n_out(bbsy_n_out),
		.bbsy_n_oe(bbsy_n_oe), .grant(grant), .hold_irq(hold_irq));
	vmr_bus_model bus_u (.pclk(pclk), .presetn(presetn), .br_n_oe(br_n_oe),
		.bbsy_n_oe(bbsy_n_oe), .other_br(other_br), .other_bbsy(other_bbsy), .lat(lat),
		.br_n_in(br_n_in), .bbsy_n_in(bbsy_n_in), .bg_in_n(bg_in_n));

	task automatic conclude();
		if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic pulse(input vmr_pkg::vmr_done_t m);
		cd <= cd | m;
		@(posedge pclk);
		cd <= cd & ~m;
		@(posedge pclk);
	endtask
	task automatic fin(input vmr_pkg::vmr_chan_t g);
		if (g == ch_irq) pulse('{iack_done: 1'b1, default: '0});
		else if (g == ch_pci) pulse('{fifo_empty: 1'b1, default: '0});
		else pulse('{dma_empty: 1'b1, default: '0});
	endtask
	// Wait for an owner; seen tells whether bus busy was let go meanwhile
	task automatic nxt(input vmr_pkg::vmr_chan_t g, input logic rel);
		logic seen;
		seen = 1'b0;
		for (int i = 0; i < 300 && grant !== g; i++) begin
			seen |= (bbsy_n_oe === 1'b1);
			@(posedge pclk);
		end
		chk(32'(grant), 32'(g));
		chk({31'h0, seen}, {31'h0, rel});
	endtask
	task automatic freed();
		for (n = 0; n < 50 && bbsy_n_oe !== 1'b1; n++) @(posedge pclk);
		chk({31'h0, bbsy_n_oe}, 32'h1);
	endtask

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			conclude();
		end
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata, rq, cd, dma_to_pci, other_br, other_bbsy} = '0;
		presetn = 1'b0;
		bclr_n = 1'b1;
		lat = 4'h1;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			apb(rows[i][73], rows[i][72:65], rows[i][64:33]);
			if (!rows[i][73]) chk(rd, rows[i][32:1]);
			chk({31'h0, err}, {31'h0, rows[i][0]});
		end
		apb(1'b0, 8'h04, 32'h0);
		chk(rd & 32'h1b, 32'h2);
		for (int lv = 0; lv < 4; lv++) begin
			apb(1'b1, 8'h00, 32'(lv) << 4);
			lat <= 4'(lv * 2);
			rq.irq_pend <= 1'b1;
			for (n = 0; n < 50 && br_n_oe === 4'hf; n++) @(posedge pclk);
			chk({28'h0, br_n_oe}, {28'h0, ~(4'h1 << lv)});
			nxt(ch_irq, 1'b1);
			chk({31'h0, bbsy_n_oe}, 32'h0);
			rq.irq_pend <= 1'b0;
			fin(ch_irq);
			freed();
		end
		apb(1'b1, 8'h00, 32'h30);
		rq <= '{irq_pend: 1'b1, posted_write_fifo_full_txn: 1'b1, dma_ready: 1'b1, default: '0};
		nxt(ch_irq, 1'b1);
		rq.irq_pend <= 1'b0;
		fin(ch_irq);
		for (n = 0; n < 300 && grant !== ch_pci && grant !== ch_dma; n++) @(posedge pclk);
		nx = grant;
		repeat (3) begin
			// Let the DMA off interval lapse so both channels compete
			if (nx == ch_pci) repeat (100) @(posedge pclk);
			fin(nx);
			nx = (nx == ch_pci) ? ch_dma : ch_pci;
			nxt(nx, 1'b1);
		end
		rq.posted_write_fifo_full_txn <= 1'b0;
		if (nx == ch_pci) fin(ch_pci);
		nxt(ch_dma, nx == ch_pci);
		fin(ch_dma);
		for (n = 0; n < 20 && grant === ch_dma; n++) @(posedge pclk);
		for (n = 0; n < 300 && grant !== ch_dma; n++) @(posedge pclk);
		chk({31'h0, n >= 79}, 32'h1);
		rq <= '0;
		fin(ch_dma);
		freed();
		apb(1'b1, 8'h00, 32'h34);
		rq <= '{irq_pend: 1'b1, posted_write_fifo_full_txn: 1'b1, default: '0};
		nxt(ch_irq, 1'b1);
		rq.irq_pend <= 1'b0;
		fin(ch_irq);
		nxt(ch_pci, 1'b0);
		other_br <= 4'h8;
		rq.posted_write_fifo_full_txn <= 1'b0;
		fin(ch_pci);
		freed();
		apb(1'b1, 8'h00, 32'h32);
		rq.irq_pend <= 1'b1;
		repeat (30) @(posedge pclk);
		chk({28'h0, br_n_oe}, 32'hf);
		other_br <= 4'h0;
		nxt(ch_irq, 1'b1);
		rq.irq_pend <= 1'b0;
		fin(ch_irq);
		freed();
		apb(1'b1, 8'h00, 32'hf30);
		rq.posted_write_fifo_full_txn <= 1'b1;
		nxt(ch_pci, 1'b1);
		rq.posted_write_fifo_full_txn <= 1'b0;
		pulse('{write_done: 1'b1, default: '0});
		freed();
		apb(1'b1, 8'h00, 32'h39);
		for (n = 0; n < 100 && hold_irq !== 1'b1; n++) @(posedge pclk);
		chk({31'h0, hold_irq}, 32'h1);
		apb(1'b0, 8'h04, 32'h0);
		chk(rd & 32'h3, 32'h1);
		rq.dma_ready <= 1'b1;
		bclr_n <= 1'b0;
		repeat (40) @(posedge pclk);
		chk({31'h0, grant === ch_dma}, 32'h0);
		chk({31'h0, bbsy_n_oe}, 32'h0);
		rq.posted_write_fifo_full_txn <= 1'b1;
		nxt(ch_pci, 1'b0);
		rq.posted_write_fifo_full_txn <= 1'b0;
		bclr_n <= 1'b1;
		fin(ch_pci);
		repeat (10) @(posedge pclk);
		chk({31'h0, bbsy_n_oe}, 32'h0);
		apb(1'b1, 8'h00, 32'h30);
		freed();
		nxt(ch_dma, 1'b1);
		rq <= '0;
		fin(ch_dma);
		freed();
		conclude();
	end
endmodule

/* testbench/vmr_bus_model.sv */
/*
 * Far side of the requester: a bus arbiter plus other masters.
 * Assumes pulled-up lines and foreign requests driven by the bench.
 */
`timescale 1ns/10ps
module vmr_bus_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [3:0] br_n_oe,
	input  wire logic       bbsy_n_oe,
	input  wire logic [3:0] other_br,
	input  wire logic       other_bbsy,
	input  wire logic [3:0] lat,
	output logic      [3:0] br_n_in,
	output logic            bbsy_n_in,
	output logic            bg_in_n
);
	int cnt;
	assign br_n_in   = br_n_oe & ~other_br;
	assign bbsy_n_in = bbsy_n_oe & ~other_bbsy;
	// Grant a free bus only, after a settable delay
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt     <= 0;
			bg_in_n <= 1'b1;
		end else if (&br_n_oe || !bbsy_n_oe) begin
			cnt     <= 0;
			bg_in_n <= 1'b1;
		end else if (bbsy_n_in) begin
			cnt     <= cnt + 1;
			bg_in_n <= (cnt < 32'(lat));
		end
	end
endmodule
